// >>> ladder_node_pkg.sv
// Constants, field layout and decode enumerations for the ladder node decoder.
// Assumes node words arrive right-aligned: a narrow node sits in bits 15..0.
package ladder_node_pkg;

    // Node word geometry
    localparam int NODE_W = 24;
    localparam int OP5_W = 5;
    localparam int OP8_W = 8;
    localparam int Z_W = 3;
    localparam int PTR16_W = 11;
    localparam int PTR24_W = 16;
    localparam int CNT16_W = 8;
    localparam int CNT24_W = 13;

    // Field positions
    localparam int OP16_LSB = 11;
    localparam int OP24_LSB = 16;
    localparam int CNT_LSB = 3;
    localparam int Z_LSB = 0;
    localparam int PTR_LSB = 0;

    // Lowest five-bit code that carries a count instead of a pointer
    localparam logic [OP5_W-1:0] XFER_FMT_MIN = 5'h1C;
    // Narrow pointer space: registers below this word, discrete bits above
    localparam logic [PTR24_W-1:0] REG_LIMIT16 = 16'h0780;
    // Largest count allowed for one wide transfer
    localparam logic [CNT24_W-1:0] XFER_MAX24 = 13'h03E7;

    // Enable bits for loaded instruction versions
    localparam int LD_W = 5;
    localparam int LD_LOOP = 0;
    localparam int LD_TBL_FROM_BLK = 1;
    localparam int LD_BLK_FROM_TBL = 2;
    localparam int LD_MESSAGE = 3;
    localparam int LD_CHECKSUM = 4;

    // Reset values
    localparam logic [OP8_W-1:0] OPCODE_RST = 8'h00;
    localparam logic [PTR24_W-1:0] POINTER_RST = 16'h0000;
    localparam logic [CNT24_W-1:0] COUNT_RST = 13'h0000;

    typedef enum logic [2:0] {
        class_invalid = 3'b000,
        class_element = 3'b001,
        class_count_time = 3'b010,
        class_math = 3'b011,
        block_transfer_class = 3'b100,
        class_matrix = 3'b101,
        class_read_write = 3'b110,
        class_executive = 3'b111
    } op_class_t;

    typedef enum logic [5:0] {
        kind_invalid = 6'b000000, column_start_op = 6'b000001, network_start_op = 6'b000010,
        io_exchange_op = 6'b000011, null_element_op = 6'b000100, horiz_short_op = 6'b000101,
        contact_open_op = 6'b000110, contact_closed_op = 6'b000111,
        contact_rise_op = 6'b001000, contact_fall_op = 6'b001001,
        coil_plain_op = 6'b001010, coil_retentive_op = 6'b001011,
        skip_constant_op = 6'b001100, skip_register_op = 6'b001101,
        constant_store_op = 6'b001110, register_ref_op = 6'b001111,
        discrete_group_op = 6'b010000, down_counter_op = 6'b010001, up_counter_op = 6'b010010,
        timer_seconds_op = 6'b010011, timer_tenths_op = 6'b010100,
        timer_hundredths_op = 6'b010101, add_op = 6'b010110, subtract_op = 6'b010111,
        multiply_op = 6'b011000, divide_op = 6'b011001, reg_to_table_op = 6'b011010,
        table_to_reg_op = 6'b011011, table_to_table_op = 6'b011100, block_move_op = 6'b011101,
        queue_in_op = 6'b011110, queue_out_op = 6'b011111, table_search_op = 6'b100000,
        status_op = 6'b100001, matrix_and_op = 6'b100010, matrix_or_op = 6'b100011,
        matrix_compare_op = 6'b100100, bit_sense_op = 6'b100101, bit_modify_op = 6'b100110,
        complement_op = 6'b100111, matrix_xor_op = 6'b101000, bit_rotate_op = 6'b101001,
        read_transfer_op = 6'b101010, write_transfer_op = 6'b101011,
        ext_memory_write_op = 6'b101100, ext_memory_read_op = 6'b101101,
        loop_control_op = 6'b101110, subroutine_jump_op = 6'b101111, label_op = 6'b110000,
        return_op = 6'b110001, extended_math_op = 6'b110010, table_from_block_op = 6'b110011,
        checksum_op = 6'b110100, network_message_op = 6'b110101,
        block_from_table_op = 6'b110110
    } op_kind_t;

endpackage : ladder_node_pkg

// >>> node_fields_if.sv
// Carrier for split node fields between the decoder and its helpers.
// Assumes one clock domain; all members are combinational.
`timescale 1ns/1ps
interface node_fields_if;
    import ladder_node_pkg::*;
    logic wide;
    logic [OP8_W-1:0] opcode;
    logic [PTR24_W-1:0] pointer;
    logic [CNT24_W-1:0] count;
    logic count_format;
    logic over_limit;
    logic discrete_area;

    modport decoder (output wide, input opcode, pointer, count, count_format, over_limit,
        discrete_area);
    modport splitter (input wide, output opcode, pointer, count, count_format);
    modport limits (input wide, pointer, count, output over_limit, discrete_area);
endinterface : node_fields_if

// >>> node_field_split.sv
// Splits a raw node word into opcode, pointer and count fields.
// Assumes the node width select is stable while the word is presented.
`timescale 1ns/1ps
module node_field_split
    import ladder_node_pkg::*;
(
    node_fields_if.splitter f,
    input wire logic [NODE_W-1:0] node_word_i
);
    always_comb begin
        logic [OP5_W-1:0] op5;
        op5 = node_word_i[OP16_LSB +: OP5_W];
        f.count_format = 1'b0;
        if (f.wide) begin
            f.opcode = node_word_i[OP24_LSB +: OP8_W];
            f.pointer = node_word_i[PTR_LSB +: PTR24_W];
            f.count = node_word_i[CNT_LSB +: CNT24_W];
            f.count_format = (node_word_i[OP24_LSB +: OP5_W] >= XFER_FMT_MIN);
        end else begin
            f.count_format = (op5 >= XFER_FMT_MIN);
            if (f.count_format) begin
                f.opcode = {node_word_i[Z_LSB +: Z_W], op5};
            end else begin
                f.opcode = {{(OP8_W-OP5_W){1'b0}}, op5};
            end
            f.pointer = {{(PTR24_W-PTR16_W){1'b0}}, node_word_i[PTR_LSB +: PTR16_W]};
            f.count = {{(CNT24_W-CNT16_W){1'b0}}, node_word_i[CNT_LSB +: CNT16_W]};
        end
    end
endmodule : node_field_split

// >>> node_range_check.sv
// Range checks on split fields: pointer region and transfer count limit.
// Assumes fields come from the splitter in the same cycle.
`timescale 1ns/1ps
module node_range_check
    import ladder_node_pkg::*;
(
    node_fields_if.limits f
);
    always_comb begin
        f.discrete_area = !f.wide && (f.pointer >= REG_LIMIT16);
        f.over_limit = f.wide && (f.count > XFER_MAX24);
    end
endmodule : node_range_check

// >>> ladder_node_opcode_decoder.sv
// Node word decoder: classifies each ladder node and presents its operand.
// Assumes node words are synchronous to mclk_i and one decode per valid.
`timescale 1ns/1ps

// Operation
// - Narrow node: top five bits are opcode
// - Wide node: top eight bits are opcode
// - Narrow elements: low eleven bits are pointer
// - Wide elements: low sixteen bits are pointer
// - Narrow pointer: registers, then discrete words
// - Codes 00-07: column, network, exchange, null, short
// - Codes 08-0D: contacts and coils
// - Codes 0E-12: skips, storage, references
// - Codes 13-17: counters and timers
// - Codes 18-1B: add, subtract, multiply, divide
// - Wide element opcode is narrow code zero-extended
// - Narrow 1C-1F: low node bits extend opcode
// - Wide transfer: top bits select, echo ignored
// - Transfer opcodes 1C through FC
// - Matrix opcodes 1D through FD
// - Read, write; extended memory on one variant
// - Transfer middle bits are register count
// - Narrow transfer count is eight bits
// - Wide count thirteen bits, above 999 flagged
// - Executive extras 5E through FE when present
// - Code BF: messaging with peer, else checksum
// - Loaded versions use resident opcodes
// - Opcode table is fixed, not reprogrammable
module ladder_node_opcode_decoder
    import ladder_node_pkg::*;
(
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic node_valid_i,
    input wire logic [NODE_W-1:0] node_word_i,
    input wire logic wide_node_i,
    input wire logic exec_extras_en_i,
    input wire logic peer_network_i,
    input wire logic ext_memory_en_i,
    input wire logic [LD_W-1:0] loaded_en_i,
    output logic decode_valid_o,
    output logic node_wide_o,
    output logic [OP8_W-1:0] opcode_o,
    output op_class_t op_class_o,
    output op_kind_t op_kind_o,
    output logic [PTR24_W-1:0] pointer_o,
    output logic pointer_valid_o,
    output logic discrete_area_o,
    output logic [CNT24_W-1:0] xfer_count_o,
    output logic count_valid_o,
    output logic count_over_limit_o,
    output logic invalid_opcode_o
);

    typedef struct packed {
        logic valid;
        logic wide;
        logic [OP8_W-1:0] opcode;
        op_class_t op_class;
        op_kind_t kind;
        logic [PTR24_W-1:0] pointer;
        logic pointer_valid;
        logic discrete;
        logic [CNT24_W-1:0] count;
        logic count_valid;
        logic over_limit;
        logic invalid;
    } dec_state_t;

    dec_state_t st_r;
    dec_state_t st_nxt;
    node_fields_if fields ();

    assign fields.wide = wide_node_i;

    node_field_split u_split (
        .f (fields.splitter),
        .node_word_i (node_word_i)
    );

    node_range_check u_check (
        .f (fields.limits)
    );

    // Fixed opcode table; only enables can hide an entry
    function automatic op_kind_t decode_kind(
        input logic [OP8_W-1:0] op,
        input logic extras,
        input logic peer,
        input logic extmem,
        input logic [LD_W-1:0] loaded
    );
        op_kind_t k;
        k = kind_invalid;
        case (op)
            8'h00, 8'h01, 8'h02, 8'h03: k = column_start_op;
            8'h04: k = network_start_op;
            8'h05: k = io_exchange_op;
            8'h06: k = null_element_op;
            8'h07: k = horiz_short_op;
            8'h08: k = contact_open_op;
            8'h09: k = contact_closed_op;
            8'h0A: k = contact_rise_op;
            8'h0B: k = contact_fall_op;
            8'h0C: k = coil_plain_op;
            8'h0D: k = coil_retentive_op;
            8'h0E: k = skip_constant_op;
            8'h0F: k = skip_register_op;
            8'h10: k = constant_store_op;
            8'h11: k = register_ref_op;
            8'h12: k = discrete_group_op;
            8'h13: k = down_counter_op;
            8'h14: k = up_counter_op;
            8'h15: k = timer_seconds_op;
            8'h16: k = timer_tenths_op;
            8'h17: k = timer_hundredths_op;
            8'h18: k = add_op;
            8'h19: k = subtract_op;
            8'h1A: k = multiply_op;
            8'h1B: k = divide_op;
            8'h1C: k = reg_to_table_op;
            8'h3C: k = table_to_reg_op;
            8'h5C: k = table_to_table_op;
            8'h7C: k = block_move_op;
            8'h9C: k = queue_in_op;
            8'hBC: k = queue_out_op;
            8'hDC: k = table_search_op;
            8'hFC: k = status_op;
            8'h1D: k = matrix_and_op;
            8'h3D: k = matrix_or_op;
            8'h5D: k = matrix_compare_op;
            8'h7D: k = bit_sense_op;
            8'h9D: k = bit_modify_op;
            8'hBD: k = complement_op;
            8'hDD: k = matrix_xor_op;
            8'hFD: k = bit_rotate_op;
            8'h1E: k = read_transfer_op;
            8'h3E: k = write_transfer_op;
            8'h7E: k = extmem ? ext_memory_write_op : kind_invalid;
            8'h9E: k = extmem ? ext_memory_read_op : kind_invalid;
            8'h5E: k = (extras || loaded[LD_LOOP]) ? loop_control_op : kind_invalid;
            8'hDE: k = extras ? subroutine_jump_op : kind_invalid;
            8'hBE: k = extras ? label_op : kind_invalid;
            8'hFE: k = extras ? return_op : kind_invalid;
            8'h7F: k = extras ? extended_math_op : kind_invalid;
            8'h9F: begin
                k = (extras || loaded[LD_TBL_FROM_BLK]) ? table_from_block_op : kind_invalid;
            end
            8'hDF: begin
                k = (extras || loaded[LD_BLK_FROM_TBL]) ? block_from_table_op : kind_invalid;
            end
            8'hBF: begin
                if (peer) begin
                    k = (extras || loaded[LD_MESSAGE]) ? network_message_op : kind_invalid;
                end else begin
                    k = (extras || loaded[LD_CHECKSUM]) ? checksum_op : kind_invalid;
                end
            end
            default: k = kind_invalid;
        endcase
        return k;
    endfunction : decode_kind

    function automatic op_class_t class_of(input op_kind_t k);
        op_class_t c;
        c = class_executive;
        if (k == kind_invalid) begin
            c = class_invalid;
        end else if (k <= discrete_group_op) begin
            c = class_element;
        end else if (k <= timer_hundredths_op) begin
            c = class_count_time;
        end else if (k <= divide_op) begin
            c = class_math;
        end else if (k <= status_op) begin
            c = block_transfer_class;
        end else if (k <= bit_rotate_op) begin
            c = class_matrix;
        end else if (k <= ext_memory_read_op) begin
            c = class_read_write;
        end
        return c;
    endfunction : class_of

    always_comb begin
        st_nxt = st_r;
        st_nxt.valid = node_valid_i;
        if (node_valid_i) begin
            st_nxt.wide = wide_node_i;
            st_nxt.opcode = fields.opcode;
            st_nxt.kind = decode_kind(fields.opcode, exec_extras_en_i, peer_network_i,
                ext_memory_en_i, loaded_en_i);
            st_nxt.op_class = class_of(st_nxt.kind);
            st_nxt.invalid = (st_nxt.kind == kind_invalid);
            st_nxt.count_valid = fields.count_format && !st_nxt.invalid;
            st_nxt.pointer_valid = !fields.count_format && !st_nxt.invalid;
            st_nxt.pointer = fields.count_format ? POINTER_RST : fields.pointer;
            st_nxt.count = fields.count_format ? fields.count : COUNT_RST;
            st_nxt.discrete = st_nxt.pointer_valid && fields.discrete_area;
            st_nxt.over_limit = st_nxt.count_valid && fields.over_limit;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            st_r <= '{valid: 1'b0, wide: 1'b0, opcode: OPCODE_RST, op_class: class_invalid,
                kind: kind_invalid, pointer: POINTER_RST, pointer_valid: 1'b0,
                discrete: 1'b0, count: COUNT_RST, count_valid: 1'b0, over_limit: 1'b0,
                invalid: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign decode_valid_o = st_r.valid;
    assign node_wide_o = st_r.wide;
    assign opcode_o = st_r.opcode;
    assign op_class_o = st_r.op_class;
    assign op_kind_o = st_r.kind;
    assign pointer_o = st_r.pointer;
    assign pointer_valid_o = st_r.pointer_valid;
    assign discrete_area_o = st_r.discrete;
    assign xfer_count_o = st_r.count;
    assign count_valid_o = st_r.count_valid;
    assign count_over_limit_o = st_r.over_limit;
    assign invalid_opcode_o = st_r.invalid;

    // Checks
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (reset_i);

    a_narrow_opcode: assert property (
        node_valid_i && !wide_node_i && (node_word_i[15:11] < 5'h1C)
        |=> opcode_o == {3'b000, $past(node_word_i[15:11])})
        else $error("narrow opcode field wrong");

    a_wide_opcode: assert property (
        node_valid_i && wide_node_i |=> opcode_o == $past(node_word_i[23:16]))
        else $error("wide opcode field wrong");

    a_narrow_pointer: assert property (
        node_valid_i && !wide_node_i && (node_word_i[15:11] < 5'h1C)
        |=> pointer_valid_o && pointer_o == {5'h00, $past(node_word_i[10:0])})
        else $error("narrow pointer wrong");

    a_wide_pointer: assert property (
        node_valid_i && wide_node_i && (node_word_i[23:16] < 8'h1C)
        |=> pointer_valid_o && pointer_o == $past(node_word_i[15:0]))
        else $error("wide pointer wrong");

    a_discrete_area: assert property (
        decode_valid_o && pointer_valid_o && !node_wide_o
        |-> discrete_area_o == (pointer_o >= 16'h0780))
        else $error("discrete area flag wrong");

    a_narrow_xfer_op: assert property (
        node_valid_i && !wide_node_i && (node_word_i[15:11] >= 5'h1C)
        |=> opcode_o == {$past(node_word_i[2:0]), $past(node_word_i[15:11])})
        else $error("narrow transfer opcode wrong");

    a_narrow_count: assert property (
        node_valid_i && !wide_node_i |=> !count_valid_o || xfer_count_o < 13'h0100)
        else $error("narrow count exceeds eight bits");

    a_count_limit: assert property (
        decode_valid_o && count_valid_o && node_wide_o
        |-> count_over_limit_o == (xfer_count_o > 13'h03E7))
        else $error("count limit flag wrong");

    a_shared_bf: assert property (
        node_valid_i && wide_node_i && node_word_i[23:16] == 8'hBF && exec_extras_en_i
        |=> op_kind_o == ($past(peer_network_i) ? network_message_op : checksum_op))
        else $error("shared code decoded wrong");

    a_invalid_flag: assert property (
        decode_valid_o |-> invalid_opcode_o == (op_kind_o == kind_invalid)
            && (invalid_opcode_o || op_class_o != class_invalid))
        else $error("invalid flag mismatch");

    a_valid_pulse: assert property (
        node_valid_i ##1 !node_valid_i |-> decode_valid_o ##1 !decode_valid_o)
        else $error("decode valid timing wrong");

    a_column_start: assert property (
        decode_valid_o && opcode_o <= 8'h03 |-> op_kind_o == column_start_op)
        else $error("column start decoded wrong");

    a_contact_open: assert property (
        decode_valid_o && opcode_o == 8'h08 |-> op_kind_o == contact_open_op)
        else $error("open contact decoded wrong");

    a_element_class: assert property (
        decode_valid_o && opcode_o < 8'h13 |-> op_class_o == class_element)
        else $error("element class wrong");

    a_count_time_class: assert property (
        decode_valid_o && opcode_o >= 8'h13 && opcode_o <= 8'h17
        |-> op_class_o == class_count_time)
        else $error("counter or timer class wrong");

    a_math_class: assert property (
        decode_valid_o && opcode_o >= 8'h18 && opcode_o <= 8'h1B |-> op_class_o == class_math)
        else $error("math class wrong");

    a_multiply_kind: assert property (
        decode_valid_o && opcode_o == 8'h1A |-> op_kind_o == multiply_op)
        else $error("multiply decoded wrong");

    a_wide_element_op: assert property (
        decode_valid_o && node_wide_o && !invalid_opcode_o && opcode_o[4:0] < 5'h1C
        |-> opcode_o[7:5] == 3'b000)
        else $error("wide element opcode not zero extended");

    a_wide_xfer_count: assert property (
        node_valid_i && wide_node_i && (node_word_i[20:16] >= 5'h1C)
        |=> count_valid_o == !invalid_opcode_o && xfer_count_o == $past(node_word_i[15:3]))
        else $error("wide transfer count wrong");

    a_xfer_class: assert property (
        decode_valid_o && opcode_o[4:0] == 5'h1C
        |-> op_class_o == block_transfer_class && count_valid_o)
        else $error("transfer class wrong");

    a_matrix_class: assert property (
        decode_valid_o && opcode_o[4:0] == 5'h1D |-> op_class_o == class_matrix)
        else $error("matrix class wrong");

    a_ext_memory_off: assert property (
        node_valid_i && wide_node_i && !ext_memory_en_i
        && (node_word_i[23:16] == 8'h7E || node_word_i[23:16] == 8'h9E)
        |=> invalid_opcode_o)
        else $error("extended memory code accepted while absent");

    a_count_no_ptr: assert property (
        decode_valid_o && count_valid_o |-> pointer_o == POINTER_RST && !pointer_valid_o)
        else $error("count node shows a pointer");

    a_exec_jump: assert property (
        node_valid_i && wide_node_i && node_word_i[23:16] == 8'hDE && exec_extras_en_i
        |=> op_kind_o == subroutine_jump_op)
        else $error("subroutine jump decoded wrong");

    a_loaded_loop: assert property (
        node_valid_i && wide_node_i && node_word_i[23:16] == 8'h5E && loaded_en_i[LD_LOOP]
        |=> op_kind_o == loop_control_op)
        else $error("loaded loop control decoded wrong");

    a_fixed_table: assert property (
        decode_valid_o && opcode_o < 8'h1C |-> !invalid_opcode_o)
        else $error("fixed element code flagged invalid");

    c_multiply: cover property (decode_valid_o && op_kind_o == multiply_op);
    c_transfer: cover property (decode_valid_o && op_class_o == block_transfer_class);
    c_over_limit: cover property (decode_valid_o && count_over_limit_o);
    c_invalid: cover property (decode_valid_o && invalid_opcode_o);

endmodule : ladder_node_opcode_decoder

// >>> node_source.sv
// Program memory model: presents one node word per call to the decoder.
// Assumes the caller enters send just after a rising edge of mclk_i.
`timescale 1ns/1ps
module node_source
    import ladder_node_pkg::*;
(
    input wire logic mclk_i,
    output logic node_valid_o,
    output logic [NODE_W-1:0] node_word_o,
    output logic wide_o
);
    initial begin
        node_valid_o = 1'b0;
        node_word_o = 24'h000000;
        wide_o = 1'b0;
    end

    // Holds the word for one edge, then scrambles the released bus
    task automatic send(input logic w, input logic [NODE_W-1:0] word);
        node_valid_o <= 1'b1;
        node_word_o <= word;
        wide_o <= w;
        @(posedge mclk_i);
        node_valid_o <= 1'b0;
        node_word_o <= ~word;
    endtask : send
endmodule : node_source

// >>> tb.sv
// Self-checking bench for the ladder node decoder.
// Assumes the node source model and the package are compiled first.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin error_cnt++; \
    $display("Error %s expected %0h seen %0h", nm, exp, got); end end
module tb;
    import ladder_node_pkg::*;
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic node_valid_i, wide_node_i, decode_valid_o, node_wide_o, pointer_valid_o;
    logic discrete_area_o, count_valid_o, count_over_limit_o, invalid_opcode_o;
    logic exec_extras_en_i = 1'b0, peer_network_i = 1'b0, ext_memory_en_i = 1'b0;
    logic [LD_W-1:0] loaded_en_i = 5'h00;
    logic [NODE_W-1:0] node_word_i;
    logic [OP8_W-1:0] opcode_o;
    logic [PTR24_W-1:0] pointer_o;
    logic [CNT24_W-1:0] xfer_count_o;
    op_class_t op_class_o;
    op_kind_t op_kind_o;
    int error_cnt = 0;
    int samples_checked = 0;
    localparam logic [7:0] EXOP [8] = '{8'h5E, 8'hDE, 8'hBE, 8'hFE, 8'h7F, 8'h9F, 8'hBF, 8'hDF};
    localparam op_kind_t EXK [8] = '{loop_control_op, subroutine_jump_op, label_op, return_op,
        extended_math_op, table_from_block_op, checksum_op, block_from_table_op};

    initial forever #12.5 mclk_i = ~mclk_i;

    node_source i_src (.mclk_i(mclk_i), .node_valid_o(node_valid_i), .node_word_o(node_word_i),
        .wide_o(wide_node_i));

    ladder_node_opcode_decoder i_dut (.mclk_i(mclk_i), .reset_i(reset_i),
        .node_valid_i(node_valid_i), .node_word_i(node_word_i), .wide_node_i(wide_node_i),
        .exec_extras_en_i(exec_extras_en_i), .peer_network_i(peer_network_i),
        .ext_memory_en_i(ext_memory_en_i), .loaded_en_i(loaded_en_i),
        .decode_valid_o(decode_valid_o), .node_wide_o(node_wide_o), .opcode_o(opcode_o),
        .op_class_o(op_class_o), .op_kind_o(op_kind_o), .pointer_o(pointer_o),
        .pointer_valid_o(pointer_valid_o), .discrete_area_o(discrete_area_o),
        .xfer_count_o(xfer_count_o), .count_valid_o(count_valid_o),
        .count_over_limit_o(count_over_limit_o), .invalid_opcode_o(invalid_opcode_o));

    task automatic report_and_stop();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop

    // Expected class from the layout of the opcode tables
    function automatic op_class_t exp_class(input logic [7:0] op);
        op_class_t c;
        c = class_executive;
        if (op < 8'h13) begin
            c = class_element;
        end else if (op < 8'h18) begin
            c = class_count_time;
        end else if (op < 8'h1C) begin
            c = class_math;
        end else if (op[4:0] == 5'h1C) begin
            c = block_transfer_class;
        end else if (op[4:0] == 5'h1D) begin
            c = class_matrix;
        end else if (op[4:0] == 5'h1E && (op[7:5] inside {3'h0, 3'h1, 3'h3, 3'h4})) begin
            c = class_read_write;
        end
        return c;
    endfunction : exp_class

    // Sends one node with enables {extras, peer, extmem, loaded} and checks the decode
    task automatic chk(input logic w, input logic [23:0] wd, input logic [7:0] ctl,
        input logic [7:0] eop, input op_kind_t ek, input logic fmt, input logic [15:0] v,
        input logic inv);
        @(posedge mclk_i);
        {exec_extras_en_i, peer_network_i, ext_memory_en_i, loaded_en_i} <= ctl;
        i_src.send(w, wd);
        #1;
        `CHK("decode_valid", 1'b1, decode_valid_o)
        `CHK("opcode", eop, opcode_o)
        `CHK("invalid", inv, invalid_opcode_o)
        `CHK("class", inv ? class_invalid : exp_class(eop), op_class_o)
        `CHK("ptr_valid", !fmt & !inv, pointer_valid_o)
        `CHK("cnt_valid", fmt & !inv, count_valid_o)
        if (!inv) begin
            `CHK("kind", ek, op_kind_o)
            `CHK("pointer", fmt ? 16'h0000 : v, pointer_o)
            `CHK("count", fmt ? v[12:0] : 13'h0000, xfer_count_o)
            `CHK("over", w & fmt & (v > 16'd999), count_over_limit_o)
            `CHK("discrete", !w & !fmt & (v >= 16'h0780), discrete_area_o)
            `CHK("wide", w, node_wide_o)
        end
    endtask : chk

    initial begin
        logic [7:0] op;
        repeat (2) @(posedge mclk_i);
        reset_i <= 1'b0;
        @(posedge mclk_i);
        #1;
        `CHK("reset_valid", 1'b0, decode_valid_o)
        for (int c = 0; c < 28; c++) begin
            chk(0, {8'h00, c[4:0], 11'h0A5}, 8'h00, 8'(c), op_kind_t'((c < 4) ? 1 : c - 2), 0,
                16'h00A5, 0);
            chk(1, {c[7:0], 16'hBEEF}, 8'h00, 8'(c), op_kind_t'((c < 4) ? 1 : c - 2), 0,
                16'hBEEF, 0);
        end
        for (int z = 0; z < 8; z++) begin
            for (int m = 0; m < 2; m++) begin
                op = {z[2:0], (m == 1) ? 5'h1D : 5'h1C};
                chk(0, {8'h00, op[4:0], 8'(z + 1), z[2:0]}, 8'h00, op, op_kind_t'(26 + 8 * m + z),
                    1, 16'(z + 1), 0);
                chk(1, {op, 13'(z + 1), ~z[2:0]}, 8'h00, op, op_kind_t'(26 + 8 * m + z), 1,
                    16'(z + 1), 0);
            end
        end
        for (int i = 0; i < 8; i++) begin
            chk(1, {EXOP[i], 16'h0008}, 8'h80, EXOP[i], EXK[i], 1, 16'h0001, 0);
        end
        chk(0, 24'hFF4123, 8'h00, 8'h08, contact_open_op, 0, 16'h0123, 0);
        chk(0, 24'h004780, 8'h00, 8'h08, contact_open_op, 0, 16'h0780, 0);
        chk(0, 24'h00477F, 8'h00, 8'h08, contact_open_op, 0, 16'h077F, 0);
        chk(0, 24'h00E7F8, 8'h00, 8'h1C, reg_to_table_op, 1, 16'h00FF, 0);
        chk(1, 24'h1C1F48, 8'h00, 8'h1C, reg_to_table_op, 1, 16'h03E9, 0);
        chk(1, 24'h3C1F3B, 8'h00, 8'h3C, table_to_reg_op, 1, 16'h03E7, 0);
        chk(0, 24'h00F000, 8'h00, 8'h1E, read_transfer_op, 1, 16'h0000, 0);
        chk(0, 24'h00F009, 8'h00, 8'h3E, write_transfer_op, 1, 16'h0001, 0);
        chk(1, 24'h7E0000, 8'h00, 8'h7E, kind_invalid, 1, 16'h0000, 1);
        chk(1, 24'h7E0000, 8'h20, 8'h7E, ext_memory_write_op, 1, 16'h0000, 0);
        chk(1, 24'h9E0000, 8'h20, 8'h9E, ext_memory_read_op, 1, 16'h0000, 0);
        chk(1, 24'hBF0000, 8'hC0, 8'hBF, network_message_op, 1, 16'h0000, 0);
        chk(1, 24'hBF0000, 8'h48, 8'hBF, network_message_op, 1, 16'h0000, 0);
        chk(1, 24'hBF0000, 8'h10, 8'hBF, checksum_op, 1, 16'h0000, 0);
        chk(1, 24'h5E0000, 8'h01, 8'h5E, loop_control_op, 1, 16'h0000, 0);
        chk(1, 24'h9F0000, 8'h02, 8'h9F, table_from_block_op, 1, 16'h0000, 0);
        chk(1, 24'hDF0000, 8'h04, 8'hDF, block_from_table_op, 1, 16'h0000, 0);
        chk(1, 24'h5E0000, 8'h00, 8'h5E, kind_invalid, 1, 16'h0000, 1);
        chk(1, 24'hDE0000, 8'h1F, 8'hDE, kind_invalid, 1, 16'h0000, 1);
        chk(1, 24'hFF0000, 8'hFF, 8'hFF, kind_invalid, 1, 16'h0000, 1);
        report_and_stop();
    end

    initial begin
        #(3000 * 25);
        error_cnt++;
        report_and_stop();
    end
endmodule : tb
